//--- core/clock_source_select.sv
// Reference clock source selection with missing clock fallback and APB regs
`timescale 1ns/1ps
`include "clock_select_map.svh"

module clock_source_select #(
  parameter int SWITCH_GAP_NS = `CS_SWITCH_GAP_NS,
  parameter int DETECT_TIMEOUT_NS = `CS_DETECT_TIMEOUT_NS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`CS_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire clock_select_pkg::osc_levels_type osc_in,
  output clock_select_pkg::clock_outs_type clk_out,
  output clock_select_pkg::pin_mode_type pin_mode,
  output logic backup_to_watchdog,
  output logic irq
);
  import clock_select_pkg::*;

  localparam int GAP_CYCLES_RAW =
    (SWITCH_GAP_NS * 1000 + `CS_CLK_PERIOD_PS - 1) / `CS_CLK_PERIOD_PS;
  localparam int GAP_CYCLES = GAP_CYCLES_RAW < 1 ? 1 : GAP_CYCLES_RAW;
  localparam int DETECT_CYCLES_RAW =
    (DETECT_TIMEOUT_NS * 1000) / `CS_CLK_PERIOD_PS;
  localparam int DETECT_CYCLES =
    DETECT_CYCLES_RAW < 1 ? 1 : DETECT_CYCLES_RAW;
  localparam int CNT_W = 16;

  typedef enum {st_run, st_gap} switch_state_type;

  // Decode source field; any unknown code falls back to the primary source
  function automatic source_type decode_source(input logic [1:0] code);
    unique case (code)
      2'h1: decode_source = src_backup;
      2'h2: decode_source = src_external;
      default: decode_source = src_primary;
    endcase
  endfunction

  function automatic logic level_of(input source_type s,
                                    input osc_levels_type lv);
    unique case (s)
      src_backup: level_of = lv.backup_ring_osc;
      src_external: level_of = lv.external_crystal_source;
      default: level_of = lv.primary_internal_osc;
    endcase
  endfunction

  logic [1:0] sel_code_reg;
  logic precision_resistor_select_reg;
  logic pll_use_reg;
  logic detect_enable_reg;
  logic [1:0] can_code_reg;
  logic oscillator_disable_reg;
  logic one_wire_clock_choice_reg;
  logic [`CS_EVENT_W-1:0] event_reg;
  logic [`CS_EVENT_W-1:0] event_mask_reg;
  logic [`CS_EDGE_W-1:0] edge_count_reg;
  logic crystal_prev_reg;
  logic ref_prev_reg;
  logic missing_reg;
  logic [CNT_W-1:0] detect_count_reg;
  logic [CNT_W-1:0] gap_count_reg;
  switch_state_type state_reg;
  source_type active_reg;
  source_type target_reg;
  logic gate_on_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  clock_outs_type clk_out_reg;

  logic setup_phase;
  logic wr_access;
  logic addr_known;
  logic sel_wr;
  logic crystal_wr;
  logic state_wr;
  logic event_wr;
  logic mask_wr;
  logic edge_wr;
  source_type wanted;
  logic ref_level;
  logic ref_edge;
  logic crystal_edge;
  logic missing_detect;
  logic switch_done;
  logic edge_full_event;
  logic [`CS_EVENT_W-1:0] event_set;
  logic [31:0] read_value;
  can_source_type can_sel;

  assign setup_phase = psel && !penable;
  assign wr_access = psel && penable && pwrite;
  assign sel_wr = wr_access && paddr == `CS_OFF_SOURCE_CTRL;
  assign crystal_wr = wr_access && paddr == `CS_OFF_CRYSTAL_CTRL;
  assign state_wr = wr_access && paddr == `CS_OFF_STATE;
  assign event_wr = wr_access && paddr == `CS_OFF_EVENT;
  assign mask_wr = wr_access && paddr == `CS_OFF_EVENT_MASK;
  assign edge_wr = wr_access && paddr == `CS_OFF_EDGE_COUNT;
  assign addr_known = paddr == `CS_OFF_SOURCE_CTRL ||
    paddr == `CS_OFF_CRYSTAL_CTRL || paddr == `CS_OFF_STATE ||
    paddr == `CS_OFF_EVENT || paddr == `CS_OFF_EVENT_MASK ||
    paddr == `CS_OFF_EDGE_COUNT;

  // Missing clock forces backup; otherwise software choice
  assign wanted = missing_reg ? src_backup :
    decode_source(sel_code_reg);
  assign can_sel = can_source_type'(can_code_reg);

  // Software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_code_reg <= `CS_SEL_RESET;
      precision_resistor_select_reg <= 1'b0;
      pll_use_reg <= 1'b0;
      detect_enable_reg <= 1'b0;
      can_code_reg <= `CS_CAN_RESET;
    end else if (sel_wr) begin
      sel_code_reg <= pwdata[`CS_SEL_MSB:`CS_SEL_LSB];
      precision_resistor_select_reg <= pwdata[`CS_PRECISION_BIT];
      pll_use_reg <= pwdata[`CS_PLL_USE_BIT];
      detect_enable_reg <= pwdata[`CS_DETECT_EN_BIT];
      can_code_reg <= pwdata[`CS_CAN_MSB:`CS_CAN_LSB];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oscillator_disable_reg <= `CS_OSC_DISABLE_RESET;
      one_wire_clock_choice_reg <= `CS_ONE_WIRE_RESET;
    end else if (crystal_wr) begin
      oscillator_disable_reg <= pwdata[`CS_OSC_DISABLE_BIT];
      one_wire_clock_choice_reg <= pwdata[`CS_ONE_WIRE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_mask_reg <= '0;
    end else if (mask_wr) begin
      event_mask_reg <= pwdata[`CS_EVENT_W-1:0];
    end
  end

  // Crystal input edge counter, saturating; a write with the clear bit set clears
  assign crystal_edge = osc_in.external_crystal_source && !crystal_prev_reg;
  assign edge_full_event = crystal_edge &&
    !(edge_wr && pwdata[`CS_EDGE_CLEAR_BIT]) &&
    edge_count_reg == `CS_EDGE_MAX - `CS_EDGE_W'(1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crystal_prev_reg <= 1'b0;
      edge_count_reg <= '0;
    end else begin
      crystal_prev_reg <= osc_in.external_crystal_source;
      if (edge_wr && pwdata[`CS_EDGE_CLEAR_BIT]) begin
        edge_count_reg <= '0;
      end else if (crystal_edge && edge_count_reg != `CS_EDGE_MAX) begin
        edge_count_reg <= edge_count_reg + `CS_EDGE_W'(1);
      end
    end
  end

  // Missing clock detector watches the active non-backup reference
  assign ref_level = level_of(active_reg, osc_in);
  assign ref_edge = ref_level && !ref_prev_reg;
  assign missing_detect = detect_enable_reg && !missing_reg &&
    state_reg == st_run && active_reg != src_backup &&
    detect_count_reg == CNT_W'(DETECT_CYCLES);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_prev_reg <= 1'b0;
      detect_count_reg <= '0;
    end else begin
      ref_prev_reg <= ref_level;
      if (ref_edge || state_reg != st_run || !detect_enable_reg) begin
        detect_count_reg <= '0;
      end else if (detect_count_reg != CNT_W'(DETECT_CYCLES)) begin
        detect_count_reg <= detect_count_reg + CNT_W'(1);
      end
    end
  end

  // Missing latch holds until software writes one to its state bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      missing_reg <= 1'b0;
    end else if (missing_detect) begin
      missing_reg <= 1'b1;
    end else if (state_wr && pwdata[`CS_ST_MISSING_BIT]) begin
      missing_reg <= 1'b0;
    end
  end

  // Break before make: gate closes, gap elapses, new source opens
  assign switch_done = state_reg == st_gap &&
    gap_count_reg == CNT_W'(GAP_CYCLES - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= st_run;
      active_reg <= src_primary;
      target_reg <= src_primary;
      gate_on_reg <= 1'b1;
      gap_count_reg <= '0;
    end else begin
      unique case (state_reg)
        st_run: begin
          if (wanted != active_reg && !ref_level) begin
            state_reg <= st_gap;
            target_reg <= wanted;
            gate_on_reg <= 1'b0;
            gap_count_reg <= '0;
          end
        end
        st_gap: begin
          if (switch_done) begin
            state_reg <= st_run;
            active_reg <= target_reg;
            gate_on_reg <= 1'b1;
          end else begin
            gap_count_reg <= gap_count_reg + CNT_W'(1);
          end
        end
      endcase
    end
  end

  // Clock outputs from flip-flops; PLL bypassed on missing clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_out_reg <= '0;
    end else begin
      clk_out_reg.reference_osc_clock <= gate_on_reg && ref_level;
      clk_out_reg.pll_bypassed <= !pll_use_reg || missing_reg;
      if (pll_use_reg && !missing_reg) begin
        clk_out_reg.system_clock <= osc_in.pll_vco_clock;
      end else begin
        clk_out_reg.system_clock <= gate_on_reg && ref_level;
      end
      unique case (can_sel)
        can_from_external:
          clk_out_reg.can_bit_clock <= osc_in.external_crystal_source;
        can_from_aux:
          clk_out_reg.can_bit_clock <= osc_in.auxiliary_clock_input;
        default:
          clk_out_reg.can_bit_clock <= gate_on_reg && ref_level;
      endcase
    end
  end

  assign clk_out = clk_out_reg;
  // Backup always feeds the watchdog output; the missing clock detector does not use it
  assign backup_to_watchdog = osc_in.backup_ring_osc;

  // Crystal pin functions
  always_comb begin
    pin_mode.osc_power_en = !oscillator_disable_reg;
    pin_mode.single_ended = one_wire_clock_choice_reg;
    pin_mode.external_resistor_mode = precision_resistor_select_reg;
    pin_mode.pin_a_gpio = oscillator_disable_reg &&
      !one_wire_clock_choice_reg && !precision_resistor_select_reg;
    pin_mode.pin_b_gpio = oscillator_disable_reg ||
      one_wire_clock_choice_reg;
  end

  // Events: set wins over a same-cycle write-one clear
  assign event_set[`CS_EV_MISSING] = missing_detect;
  assign event_set[`CS_EV_SWITCHED] = switch_done;
  assign event_set[`CS_EV_EDGE_FULL] = edge_full_event;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_reg <= '0;
    end else if (event_wr) begin
      event_reg <= (event_reg & ~pwdata[`CS_EVENT_W-1:0]) | event_set;
    end else begin
      event_reg <= event_reg | event_set;
    end
  end

  assign irq = |(event_reg & event_mask_reg);

  // Read mux
  always_comb begin
    read_value = '0;
    unique case (paddr)
      `CS_OFF_SOURCE_CTRL: begin
        read_value[`CS_SEL_MSB:`CS_SEL_LSB] = sel_code_reg;
        read_value[`CS_PRECISION_BIT] = precision_resistor_select_reg;
        read_value[`CS_PLL_USE_BIT] = pll_use_reg;
        read_value[`CS_DETECT_EN_BIT] = detect_enable_reg;
        read_value[`CS_CAN_MSB:`CS_CAN_LSB] = can_code_reg;
      end
      `CS_OFF_CRYSTAL_CTRL: begin
        read_value[`CS_OSC_DISABLE_BIT] = oscillator_disable_reg;
        read_value[`CS_ONE_WIRE_BIT] = one_wire_clock_choice_reg;
      end
      `CS_OFF_STATE: begin
        read_value[`CS_ST_ACTIVE_MSB:`CS_ST_ACTIVE_LSB] = active_reg;
        read_value[`CS_ST_MISSING_BIT] = missing_reg;
        read_value[`CS_ST_SWITCHING_BIT] = state_reg == st_gap;
        read_value[`CS_ST_PLL_BYPASS_BIT] = clk_out_reg.pll_bypassed;
        read_value[`CS_ST_PIN_A_GPIO_BIT] = pin_mode.pin_a_gpio;
        read_value[`CS_ST_PIN_B_GPIO_BIT] = pin_mode.pin_b_gpio;
      end
      `CS_OFF_EVENT: read_value[`CS_EVENT_W-1:0] = event_reg;
      `CS_OFF_EVENT_MASK: read_value[`CS_EVENT_W-1:0] = event_mask_reg;
      `CS_OFF_EDGE_COUNT: read_value[`CS_EDGE_W-1:0] = edge_count_reg;
      default: read_value = '0;
    endcase
  end

  // Read data and error captured in setup, presented in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
      pslverr_reg <= 1'b0;
    end else if (setup_phase) begin
      prdata_reg <= pwrite ? 32'h0000_0000 : read_value;
      pslverr_reg <= !addr_known;
    end
  end

  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg && psel && penable;
  assign pready = 1'b1;

endmodule

//--- core/clock_select_map.svh
// Register offsets, field positions, reset values and timing for clock select
`ifndef CLOCK_SELECT_MAP_SVH
`define CLOCK_SELECT_MAP_SVH

`define CS_ADDR_W 8
`define CS_OFF_SOURCE_CTRL 8'h00
`define CS_OFF_CRYSTAL_CTRL 8'h04
`define CS_OFF_STATE 8'h08
`define CS_OFF_EVENT 8'h0c
`define CS_OFF_EVENT_MASK 8'h10
`define CS_OFF_EDGE_COUNT 8'h14

// Source control fields
`define CS_SEL_LSB 0
`define CS_SEL_MSB 1
`define CS_PRECISION_BIT 2
`define CS_PLL_USE_BIT 3
`define CS_DETECT_EN_BIT 4
`define CS_CAN_LSB 5
`define CS_CAN_MSB 6
`define CS_SEL_RESET 2'h0
`define CS_CAN_RESET 2'h0

// Crystal control fields
`define CS_OSC_DISABLE_BIT 0
`define CS_ONE_WIRE_BIT 1
`define CS_OSC_DISABLE_RESET 1'h1
`define CS_ONE_WIRE_RESET 1'h0

// State fields
`define CS_ST_ACTIVE_LSB 0
`define CS_ST_ACTIVE_MSB 1
`define CS_ST_MISSING_BIT 2
`define CS_ST_SWITCHING_BIT 3
`define CS_ST_PLL_BYPASS_BIT 4
`define CS_ST_PIN_A_GPIO_BIT 5
`define CS_ST_PIN_B_GPIO_BIT 6

// Event bits
`define CS_EVENT_W 3
`define CS_EV_MISSING 0
`define CS_EV_SWITCHED 1
`define CS_EV_EDGE_FULL 2

// Edge counter
`define CS_EDGE_W 11
`define CS_EDGE_MAX 11'h7ff
`define CS_EDGE_CLEAR_BIT 0

// Timing
`define CS_CLK_PERIOD_PS 8000
`define CS_SWITCH_GAP_NS 200
`define CS_DETECT_TIMEOUT_NS 1000

`endif

//--- core/clock_select_pkg.sv
// Types shared by the clock source selection logic
package clock_select_pkg;

  typedef enum logic [1:0] {
    src_primary = 2'h0,
    src_backup = 2'h1,
    src_external = 2'h2
  } source_type;

  typedef enum logic [1:0] {
    can_from_sys = 2'h0,
    can_from_external = 2'h1,
    can_from_aux = 2'h2
  } can_source_type;

  typedef struct packed {
    logic [6:0] paddr;
    logic [31:0] pwdata;
  } unused_type;

  typedef struct packed {
    logic osc_power_en;
    logic single_ended;
    logic pin_a_gpio;
    logic pin_b_gpio;
    logic external_resistor_mode;
  } pin_mode_type;

  typedef struct packed {
    logic primary_internal_osc;
    logic backup_ring_osc;
    logic external_crystal_source;
    logic auxiliary_clock_input;
    logic pll_vco_clock;
  } osc_levels_type;

  typedef struct packed {
    logic reference_osc_clock;
    logic system_clock;
    logic can_bit_clock;
    logic pll_bypassed;
  } clock_outs_type;

endpackage

//--- dv/clock_select_checker.sv
// Port-level assertions for the clock source selector
`timescale 1ns/1ps
module clock_select_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pslverr,
  input wire clock_select_pkg::osc_levels_type osc_in,
  input wire clock_select_pkg::clock_outs_type clk_out,
  input wire clock_select_pkg::pin_mode_type pin_mode,
  input wire logic backup_to_watchdog
);
  import clock_select_pkg::*;
  logic refc;
  assign refc = clk_out.reference_osc_clock;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_reset_pins: assert property ($rose(presetn) |->
    !pin_mode.osc_power_en && pin_mode.pin_a_gpio && pin_mode.pin_b_gpio &&
    !pin_mode.external_resistor_mode) else $error("pins not free at reset");
  chk_reset_source: assert property ($rose(presetn) |->
    ##2 refc == $past(osc_in.primary_internal_osc))
    else $error("reference not primary after reset");
  chk_pin_a_mode: assert property (pin_mode.pin_a_gpio ==
    (!pin_mode.osc_power_en && !pin_mode.single_ended &&
    !pin_mode.external_resistor_mode)) else $error("input pin mode wrong");
  chk_pin_b_mode: assert property (pin_mode.pin_b_gpio ==
    !(pin_mode.osc_power_en && !pin_mode.single_ended))
    else $error("output pin mode wrong");
  chk_watchdog_feed: assert property (
    backup_to_watchdog == osc_in.backup_ring_osc)
    else $error("watchdog clock not backup");
  chk_ref_source: assert property (refc |->
    $past(osc_in.primary_internal_osc) || $past(osc_in.backup_ring_osc) ||
    $past(osc_in.external_crystal_source))
    else $error("reference high with no source high");
  chk_pll_path: assert property (
    $past(presetn, 2) && !clk_out.pll_bypassed |->
    clk_out.system_clock == $past(osc_in.pll_vco_clock))
    else $error("system clock not from pll");
  chk_bypass_ref: assert property (clk_out.pll_bypassed |->
    clk_out.system_clock == refc) else $error("bypass not reference");
  chk_low_hold: assert property ($fell(refc) |=> !refc)
    else $error("short low pulse on reference");
  chk_err_phase: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
endmodule

bind clock_source_select clock_select_checker clock_select_checker_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pslverr(pslverr), .osc_in(osc_in), .clk_out(clk_out),
  .pin_mode(pin_mode), .backup_to_watchdog(backup_to_watchdog)
);

//--- dv/osc_model.sv
// Behavioural oscillator and pll levels feeding the clock selector
`timescale 1ns/1ps
module osc_model (
  input wire logic pclk,
  input wire logic ext_stop,
  output clock_select_pkg::osc_levels_type osc_in
);
  import clock_select_pkg::*;
  logic [2:0] tick = 3'h0;
  logic [1:0] third = 2'h0;
  logic slow = 1'b0;
  logic ext_lvl;
  always @(posedge pclk) begin
    tick <= tick + 3'h1;
    third <= (third == 2'h2) ? 2'h0 : third + 2'h1;
    if (third == 2'h2) begin
      slow <= !slow;
    end
  end
  // A failed crystal stops low
  assign ext_lvl = !ext_stop && (tick[0] ^ tick[1]);
  assign osc_in = {tick[1], slow, ext_lvl, tick[2], tick[0]};
endmodule

//--- dv/clock_source_select_test.sv
// Register-level tests of the clock source selector
`timescale 1ns/1ps
`include "clock_select_map.svh"
module clock_source_select_test;
  import clock_select_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ext_stop = 1'b0;
  logic irq;
  logic backup_to_watchdog;
  osc_levels_type osc_in;
  clock_outs_type clk_out;
  pin_mode_type pin_mode;
  int fails = 0;
  int n_tests = 0;
  logic [31:0] r;
  logic e;

  always #4 pclk = ~pclk;

  clock_source_select #(.SWITCH_GAP_NS(16), .DETECT_TIMEOUT_NS(80))
    clock_source_select_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_in(osc_in),
    .clk_out(clk_out), .pin_mode(pin_mode),
    .backup_to_watchdog(backup_to_watchdog), .irq(irq));
  osc_model osc_model_i (.pclk(pclk), .ext_stop(ext_stop), .osc_in(osc_in));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task wait_irq(input int lim);
    int k;
    k = 0;
    while (irq !== 1'b1 && k < lim) begin
      @(posedge pclk);
      #1;
      k++;
    end
    check({31'h0, irq}, 32'h1);
  endtask

  // Output o must repeat source s one cycle late
  task follow(input int o, input int s);
    logic lv;
    lv = osc_in[s];
    repeat (8) begin
      @(posedge pclk);
      #1;
      check({31'h0, clk_out[o]}, {31'h0, lv});
      lv = osc_in[s];
    end
  endtask

  task edge_round();
    int k;
    do begin
      apb(1'b1, `CS_OFF_EDGE_COUNT, 32'h1);
      apb(1'b0, `CS_OFF_EDGE_COUNT, 32'h0);
    end while (r[10:0] === `CS_EDGE_MAX);
    k = 0;
    while (r[10:0] !== `CS_EDGE_MAX && k < 5000) begin
      apb(1'b0, `CS_OFF_EDGE_COUNT, 32'h0);
      k++;
    end
    check(r, {21'h0, `CS_EDGE_MAX});
  endtask

  task give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    #720000;
    fails++;
    give_verdict();
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `CS_OFF_SOURCE_CTRL, 32'h0);
    check(r, 32'h0);
    apb(1'b0, `CS_OFF_CRYSTAL_CTRL, 32'h0);
    check(r, 32'h1);
    apb(1'b0, `CS_OFF_STATE, 32'h0);
    check(r & 32'h67, 32'h60);
    follow(3, 4);
    follow(2, 4);
    follow(1, 4);
    apb(1'b0, 8'h40, 32'h0);
    check({e, r[30:0]}, 32'h80000000);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `CS_OFF_CRYSTAL_CTRL, 32'(i));
      check({30'h0, pin_mode.pin_a_gpio, pin_mode.pin_b_gpio},
        {30'h0, i == 1, i != 0});
    end
    apb(1'b1, `CS_OFF_CRYSTAL_CTRL, 32'h1);
    apb(1'b1, `CS_OFF_SOURCE_CTRL, 32'h4);
    check({pin_mode.external_resistor_mode, pin_mode.pin_a_gpio},
      32'h2);
    apb(1'b1, `CS_OFF_SOURCE_CTRL, 32'h3);
    apb(1'b0, `CS_OFF_STATE, 32'h0);
    check(r & 32'h3, 32'h0);
    follow(3, 4);
    apb(1'b1, `CS_OFF_SOURCE_CTRL, 32'h0);
    apb(1'b1, `CS_OFF_EVENT_MASK, 32'h2);
    apb(1'b1, `CS_OFF_SOURCE_CTRL, 32'h1);
    wait_irq(200);
    apb(1'b0, `CS_OFF_STATE, 32'h0);
    check(r & 32'h3, 32'h1);
    follow(3, 3);
    apb(1'b1, `CS_OFF_EVENT_MASK, 32'h0);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, `CS_OFF_EVENT_MASK, 32'h2);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, `CS_OFF_EVENT, 32'h2);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, `CS_OFF_CRYSTAL_CTRL, 32'h0);
    repeat (4) edge_round();
    apb(1'b0, `CS_OFF_EVENT, 32'h0);
    check(r & 32'h4, 32'h4);
    apb(1'b1, `CS_OFF_EVENT, 32'h4);
    apb(1'b1, `CS_OFF_SOURCE_CTRL, 32'h42);
    wait_irq(200);
    apb(1'b0, `CS_OFF_STATE, 32'h0);
    check(r & 32'h3, 32'h2);
    follow(3, 2);
    follow(1, 1);
    apb(1'b1, `CS_OFF_SOURCE_CTRL, 32'h2a);
    follow(1, 2);
    follow(2, 0);
    apb(1'b1, `CS_OFF_EVENT, 32'h2);
    apb(1'b1, `CS_OFF_EVENT_MASK, 32'h1);
    apb(1'b1, `CS_OFF_SOURCE_CTRL, 32'h3a);
    @(posedge pclk);
    ext_stop <= 1'b1;
    wait_irq(100);
    repeat (40) @(posedge pclk);
    apb(1'b0, `CS_OFF_STATE, 32'h0);
    check(r & 32'h17, 32'h15);
    follow(2, 3);
    give_verdict();
  end
endmodule
